// File: ctrb_arb.sv
// Picks the pending buffer of highest priority, lowest index on a tie
module ctrb_arb (
    input wire logic [5:0] pend_in,
    input wire logic [11:0] prio_in,
    output logic valid_out,
    output logic [2:0] idx_out
);
    logic [1:0] best_p;

    // Strict compare keeps the earlier index among equal levels
    always_comb
    begin
        valid_out = 1'b0;
        idx_out = 3'h0;
        best_p = 2'h0;
        for (int i = 0; i < 6; i++)
        begin
            if (pend_in[i] && (!valid_out || prio_in[2*i +: 2] > best_p))
            begin
                valid_out = 1'b1;
                idx_out = 3'(i);
                best_p = prio_in[2*i +: 2];
            end
        end
    end

endmodule : ctrb_arb

// File: ctrb_buf.sv
`include "ctrb_defs.svh"

// One message buffer: control byte, identifier bytes, full flag
module ctrb_buf (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic dir_in,
    input wire logic busy_in,
    input wire logic wr_in,
    input wire logic [2:0] sel_in,
    input wire logic [7:0] wdata_in,
    input wire logic rx_load_in,
    input wire ctrb_pkg::ctrb_rxf_s rx_frame_in,
    input wire logic rtr_hit_in,
    input wire logic done_in,
    input wire logic arb_lost_in,
    input wire logic bus_err_in,
    input wire logic aborted_in,
    output logic [7:0] rd_out,
    output logic pend_out,
    output logic [1:0] prio_out,
    output logic [28:0] id_out,
    output logic ext_out,
    output logic sent_out,
    output logic abort_pend_out
);
    ctrb_pkg::ctrb_buf_s st_r;
    ctrb_pkg::ctrb_buf_s st_nxt;
    logic locked;

    // Buffer is frozen while queued or on the wire
    assign locked = st_r.req | busy_in;

    // Next state: software first, then hardware events so that a set wins
    always_comb
    begin
        st_nxt = st_r;
        if (wr_in && dir_in && sel_in == `CTRB_REG_CTRL)
        begin
            if (locked)
            begin
                if (st_r.req && !wdata_in[`CTRB_CTL_REQ])
                begin
                    if (busy_in)
                        st_nxt.abort_pend = 1'b1;
                    else
                    begin
                        st_nxt.req = 1'b0;
                        st_nxt.abt = 1'b1;
                    end
                end
            end
            else
            begin
                st_nxt.sent = wdata_in[`CTRB_CTL_SENT];
                st_nxt.rtr_en = wdata_in[`CTRB_CTL_RTR];
                st_nxt.prio = wdata_in[`CTRB_CTL_PRI];
                if (wdata_in[`CTRB_CTL_REQ])
                begin
                    st_nxt.req = 1'b1;
                    st_nxt.sent = 1'b0;
                    st_nxt.abt = 1'b0;
                    st_nxt.arb = 1'b0;
                    st_nxt.err = 1'b0;
                end
            end
        end
        // Receive mode: software may only clear the full flag
        if (wr_in && !dir_in && sel_in == `CTRB_REG_CTRL && !wdata_in[`CTRB_CTL_FULL])
            st_nxt.full = 1'b0;
        // Identifier bytes writable only in transmit mode and when idle
        if (wr_in && dir_in && !locked)
        begin
            unique case (sel_in)
                `CTRB_REG_IDH: st_nxt.sidh = wdata_in;
                `CTRB_REG_IDL:
                begin
                    st_nxt.sidl = wdata_in[`CTRB_IDL_SID];
                    st_nxt.ext = wdata_in[`CTRB_IDL_EXT];
                    st_nxt.e1716 = wdata_in[`CTRB_IDL_E1716];
                end
                `CTRB_REG_EIDH: st_nxt.eidh = wdata_in;
                `CTRB_REG_EIDL: st_nxt.eidl = wdata_in;
                default: ;
            endcase
        end
        // Remote request answered automatically when enabled
        if (rtr_hit_in && dir_in && st_r.rtr_en && !busy_in)
        begin
            st_nxt.req = 1'b1;
            st_nxt.sent = 1'b0;
            st_nxt.abt = 1'b0;
            st_nxt.arb = 1'b0;
            st_nxt.err = 1'b0;
        end
        // Outcome of a transmission attempt
        if (arb_lost_in)
            st_nxt.arb = 1'b1;
        if (bus_err_in)
            st_nxt.err = 1'b1;
        if (aborted_in)
        begin
            st_nxt.req = 1'b0;
            st_nxt.abt = 1'b1;
            st_nxt.abort_pend = 1'b0;
        end
        if (done_in)
        begin
            st_nxt.sent = 1'b1;
            st_nxt.req = 1'b0;
            st_nxt.abort_pend = 1'b0;
        end
        // Received frame lands only in an empty receive buffer
        if (rx_load_in && !dir_in && !st_r.full)
        begin
            st_nxt.full = 1'b1;
            st_nxt.ext = rx_frame_in.ext;
            st_nxt.srr = rx_frame_in.ext & rx_frame_in.srr;
            if (rx_frame_in.ext)
            begin
                st_nxt.sidh = rx_frame_in.id[28:21];
                st_nxt.sidl = rx_frame_in.id[20:18];
                st_nxt.e1716 = rx_frame_in.id[17:16];
                st_nxt.eidh = rx_frame_in.id[15:8];
                st_nxt.eidl = rx_frame_in.id[7:0];
            end
            else
            begin
                st_nxt.sidh = rx_frame_in.id[10:3];
                st_nxt.sidl = rx_frame_in.id[2:0];
                st_nxt.e1716 = 2'h0;
                st_nxt.eidh = 8'h00;
                st_nxt.eidl = 8'h00;
            end
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // Read view by direction; unimplemented bits read zero
    always_comb
    begin
        rd_out = `CTRB_BYTE_RST;
        unique case (sel_in)
            `CTRB_REG_CTRL: rd_out = dir_in ? {st_r.sent, st_r.abt, st_r.arb, st_r.err,
                st_r.req, st_r.rtr_en, st_r.prio} : {st_r.full, 7'h00};
            `CTRB_REG_IDH: rd_out = st_r.sidh;
            `CTRB_REG_IDL: rd_out = {st_r.sidl, st_r.srr & ~dir_in, st_r.ext, 1'b0,
                st_r.e1716};
            `CTRB_REG_EIDH: rd_out = st_r.eidh;
            `CTRB_REG_EIDL: rd_out = st_r.eidl;
            default: rd_out = `CTRB_BYTE_RST;
        endcase
    end

    // Identifier to send is built from the id bytes, never from priority
    assign id_out = st_r.ext ? {st_r.sidh, st_r.sidl, st_r.e1716, st_r.eidh, st_r.eidl}
        : {18'h00000, st_r.sidh, st_r.sidl};
    assign ext_out = st_r.ext;
    assign pend_out = st_r.req & dir_in;
    assign prio_out = st_r.prio;
    assign sent_out = st_r.sent & dir_in;
    assign abort_pend_out = st_r.abort_pend;

endmodule : ctrb_buf

// File: ctrb_chk_sva.sv
// Watches the top level ports for bus timing and engine link relations
module ctrb_chk (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire ctrb_pkg::ctrb_txev_s tx_ev_in,
    input wire ctrb_pkg::ctrb_txq_s tx_req_out,
    input wire logic [5:0] abort_req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    // Register bus answers
    a_wait_one: assert property (hsel_in && htrans_in[1] && hready_in |=>
        !hreadyout_out ##1 hreadyout_out) else $error("wait state not one cycle");
    a_resp_okay: assert property (hresp_out == 1'h0) else $error("response not okay");
    a_rdata_upper: assert property (hrdata_out[31:8] == 24'h0)
        else $error("upper read bits set");
    a_rdata_stands: assert property (hreadyout_out && $past(hreadyout_out) |->
        $stable(hrdata_out)) else $error("read data moved");
    // Engine link
    a_grant_takes: assert property (tx_req_out.valid && tx_ev_in.grant |->
        ##[1:2] !tx_req_out.valid) else $error("offer stays after grant");
    a_std_upper: assert property (tx_req_out.valid && !tx_req_out.ext |->
        tx_req_out.id[28:11] == 18'h0) else $error("standard id has upper bits");
    a_idx_range: assert property (tx_req_out.valid |-> tx_req_out.buf_idx <= 3'h5)
        else $error("buffer index out of range");
    a_abort_ends: assert property ((|abort_req_out) &&
        (tx_ev_in.aborted || tx_ev_in.done) |-> ##[1:2] abort_req_out == 6'h00)
        else $error("abort request not dropped");
    a_abort_one: assert property ($onehot0(abort_req_out)) else $error("two aborts");
    c_done: cover property (tx_ev_in.done);
    c_arb: cover property (tx_ev_in.arb_lost);
    c_abort: cover property (|abort_req_out);
endmodule : ctrb_chk

// File: ctrb_defs.svh
`ifndef CTRB_DEFS_SVH
`define CTRB_DEFS_SVH

// Buffer count and per-buffer register index within a buffer window
`define CTRB_NBUF 6
`define CTRB_NREG 3'h5
`define CTRB_REG_CTRL 3'h0
`define CTRB_REG_IDH 3'h1
`define CTRB_REG_IDL 3'h2
`define CTRB_REG_EIDH 3'h3
`define CTRB_REG_EIDL 3'h4

// Byte addresses of the block-wide registers
`define CTRB_ADDR_DIRSEL 8'hC0
`define CTRB_ADDR_MODE 8'hC4
`define CTRB_ADDR_IRQEN 8'hC8
`define CTRB_ADDR_STATUS 8'hCC

// Control byte fields in transmit mode
`define CTRB_CTL_SENT 7
`define CTRB_CTL_ABT 6
`define CTRB_CTL_ARB 5
`define CTRB_CTL_ERR 4
`define CTRB_CTL_REQ 3
`define CTRB_CTL_RTR 2
`define CTRB_CTL_PRI 1:0

// Control byte field in receive mode
`define CTRB_CTL_FULL 7

// Identifier low byte fields
`define CTRB_IDL_SID 7:5
`define CTRB_IDL_SRR 4
`define CTRB_IDL_EXT 3
`define CTRB_IDL_E1716 1:0

// Direction select field position and operating modes
`define CTRB_DIR_LSB 2
`define CTRB_MODE_LEGACY 2'h0

// Reset values
`define CTRB_BYTE_RST 8'h00
`define CTRB_MODE_RST 2'h0
`define CTRB_DIR_RST 6'h00
`define CTRB_IRQEN_RST 6'h00

`endif

// File: ctrb_eng_model.sv
// Protocol engine stand-in: takes the offer, ends it as commanded
module ctrb_eng_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire ctrb_pkg::ctrb_txq_s tx_req_in,
    input wire logic [5:0] abort_req_in,
    input wire logic go_in,
    input wire logic [1:0] code_in,
    output ctrb_pkg::ctrb_txev_s ev_out,
    output logic [2:0] idx_out,
    output logic [28:0] id_out,
    output logic ext_out,
    output int cnt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // One grant pulse, a short frame, then exactly one ending pulse
    initial
    begin
        ev_out = '0;
        cnt_out = 0;
        forever
        begin
            @(posedge clk_in);
            if (rst_b_in && go_in && tx_req_in.valid)
            begin
                idx_out <= tx_req_in.buf_idx;
                id_out <= tx_req_in.id;
                ext_out <= tx_req_in.ext;
                ev_out.grant <= 1'h1;
                @(posedge clk_in);
                ev_out.grant <= 1'h0;
                repeat (2) @(posedge clk_in);
                // Code 3 holds the wire until an abort is wanted
                while (code_in == 2'h3 && !abort_req_in[idx_out]) @(posedge clk_in);
                ev_out.done <= code_in == 2'h0;
                ev_out.arb_lost <= code_in == 2'h1;
                ev_out.bus_err <= code_in == 2'h2;
                ev_out.aborted <= code_in == 2'h3;
                @(posedge clk_in);
                ev_out <= '0;
                cnt_out <= cnt_out + 1;
                @(posedge clk_in);
            end
        end
    end
endmodule : ctrb_eng_model

// File: ctrb_pkg.sv
package ctrb_pkg;

    // Bus slave state, one-hot
    typedef enum logic [1:0] {
        CTRB_BUS_IDLE = 2'b01,
        CTRB_BUS_EXEC = 2'b10
    } ctrb_bus_e;

    // Received frame as handed over by the protocol engine
    typedef struct packed {
        logic [28:0] id;
        logic ext;
        logic srr;
    } ctrb_rxf_s;

    // Events from the protocol engine about the buffer being sent
    typedef struct packed {
        logic grant;
        logic done;
        logic arb_lost;
        logic bus_err;
        logic aborted;
    } ctrb_txev_s;

    // Transmit request offered to the protocol engine
    typedef struct packed {
        logic valid;
        logic [2:0] buf_idx;
        logic [28:0] id;
        logic ext;
    } ctrb_txq_s;

    // State of one message buffer
    typedef struct packed {
        logic sent;
        logic abt;
        logic arb;
        logic err;
        logic req;
        logic rtr_en;
        logic [1:0] prio;
        logic full;
        logic abort_pend;
        logic ext;
        logic srr;
        logic [7:0] sidh;
        logic [2:0] sidl;
        logic [1:0] e1716;
        logic [7:0] eidh;
        logic [7:0] eidl;
    } ctrb_buf_s;

    // State of the top level
    typedef struct packed {
        ctrb_bus_e bus;
        logic hreadyout;
        logic [31:0] hrdata;
        logic a_write;
        logic a_ok;
        logic [7:0] a_addr;
        logic [1:0] mode;
        logic [5:0] dir;
        logic [5:0] irq_en;
        logic busy;
        logic [2:0] busy_idx;
        ctrb_txq_s txq;
        logic [5:0] abort_req;
        logic irq;
    } ctrb_top_s;

endpackage : ctrb_pkg

// File: ctrb_top.sv
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`include "ctrb_defs.svh"

// Function
// - Successful transmission sets the sent flag in control bit 7.
// - An aborted pending message sets the aborted flag in bit 6.
// - Lost arbitration during an attempt sets the flag in bit 5.
// - A bus error during an attempt sets the flag in bit 4.
// - Setting send request queues the buffer and clears all four flags.
// - Send request clears itself after a successful transmission.
// - Writing zero to a set send request asks to abort that message.
// - With auto reply enabled, a matching remote request sets send request.
// - Two-bit priority, 3 highest and 0 lowest.
// - Priority orders pending buffers only, never changes the identifier.
// - Registers ignore writes while queued or during transmission, except a write clearing send request.
// - Buffer registers exist only in modes 1, 2 and 3, not in legacy mode 0.
// - Six buffers, each showing the layout of its own direction.
// - Id high byte holds standard bits 10-3 or extended bits 28-21.
// - Id low byte holds bits 2-0 or 20-18 high, extended 17-16 low.
// - Receive frame-format bit is one for extended frames.
// - Receive bit 4 reports substitute remote request of extended frames.
// - Transmit frame-format bit selects standard or 29-bit extended frame.
// - Extended high and low bytes hold id bits 15-8 and 7-0.
// - Receive id bytes are loaded by hardware, transmit ones by software.
// - Unimplemented bits read zero.
// - Direction bit one means transmit, zero means receive.
// - Receive sets full flag and loads nothing more until software clears it.
module ctrb_top (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire ctrb_pkg::ctrb_txev_s tx_ev_in,
    input wire logic rx_load_in,
    input wire logic [2:0] rx_buf_in,
    input wire ctrb_pkg::ctrb_rxf_s rx_frame_in,
    input wire logic rtr_hit_in,
    input wire logic [2:0] rtr_buf_in,
    output ctrb_pkg::ctrb_txq_s tx_req_out,
    output logic [5:0] abort_req_out,
    output logic irq_out
);
    logic [1:0] rst_sync_r;
    logic rst_b;
    ctrb_pkg::ctrb_top_s st_r;
    ctrb_pkg::ctrb_top_s st_nxt;

    // Address decode of the captured address phase
    logic [2:0] a_idx;
    logic [2:0] a_reg;
    logic mode_on;
    logic buf_hit;
    logic exec;
    logic addr_phase;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;

    // Per-buffer signals
    logic [5:0] wr_v;
    logic [5:0] busy_v;
    logic [5:0] rx_v;
    logic [5:0] rtr_v;
    logic [5:0] done_v;
    logic [5:0] arb_v;
    logic [5:0] err_v;
    logic [5:0] abt_v;
    logic [5:0] pend_v;
    logic [5:0] sent_v;
    logic [5:0] apend_v;
    logic [5:0] ext_v;
    logic [11:0] prio_v;
    logic [7:0] rd_a [6];
    logic [28:0] id_a [6];
    logic sel_valid;
    logic [2:0] sel_idx;
    logic ev_end;
    logic grant_ok;

    // Reset release through two flops
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    assign rst_b = rst_sync_r[1];

    // Decode of the transfer held for its data phase
    assign a_idx = st_r.a_addr[7:5];
    assign a_reg = st_r.a_addr[4:2];
    assign mode_on = st_r.mode != `CTRB_MODE_LEGACY;
    assign buf_hit = st_r.a_ok && mode_on && a_idx < 3'(`CTRB_NBUF) && a_reg < `CTRB_NREG;
    assign exec = st_r.bus == ctrb_pkg::CTRB_BUS_EXEC;
    assign addr_phase = hsel_in & htrans_in[1] & hready_in;
    assign wbyte = hwdata_in[7:0];

    // Strobes and event routing for each buffer
    always_comb
    begin
        for (int i = 0; i < `CTRB_NBUF; i++)
        begin
            wr_v[i] = exec && st_r.a_write && buf_hit && a_idx == 3'(i);
            busy_v[i] = st_r.busy && st_r.busy_idx == 3'(i);
            rx_v[i] = rx_load_in && mode_on && rx_buf_in == 3'(i);
            rtr_v[i] = rtr_hit_in && mode_on && rtr_buf_in == 3'(i);
            done_v[i] = busy_v[i] & tx_ev_in.done;
            arb_v[i] = busy_v[i] & tx_ev_in.arb_lost;
            err_v[i] = busy_v[i] & tx_ev_in.bus_err;
            abt_v[i] = busy_v[i] & tx_ev_in.aborted;
        end
    end

    // Six buffers, each steered by its own direction bit
    for (genvar g = 0; g < `CTRB_NBUF; g++)
    begin : g_buf
        ctrb_buf u_buf (
            .clk_in(clk_in),
            .rst_b_in(rst_b),
            .dir_in(st_r.dir[g]),
            .busy_in(busy_v[g]),
            .wr_in(wr_v[g]),
            .sel_in(a_reg),
            .wdata_in(wbyte),
            .rx_load_in(rx_v[g]),
            .rx_frame_in(rx_frame_in),
            .rtr_hit_in(rtr_v[g]),
            .done_in(done_v[g]),
            .arb_lost_in(arb_v[g]),
            .bus_err_in(err_v[g]),
            .aborted_in(abt_v[g]),
            .rd_out(rd_a[g]),
            .pend_out(pend_v[g]),
            .prio_out(prio_v[2*g +: 2]),
            .id_out(id_a[g]),
            .ext_out(ext_v[g]),
            .sent_out(sent_v[g]),
            .abort_pend_out(apend_v[g])
        );
    end

    // Choice of the next buffer to offer for transmission
    ctrb_arb u_arb (
        .pend_in(pend_v),
        .prio_in(prio_v),
        .valid_out(sel_valid),
        .idx_out(sel_idx)
    );

    // Read data of the addressed register; unmapped reads return zero
    always_comb
    begin
        rd_byte = `CTRB_BYTE_RST;
        if (buf_hit)
        begin
            for (int i = 0; i < `CTRB_NBUF; i++)
            begin
                if (a_idx == 3'(i))
                    rd_byte = rd_a[i];
            end
        end
        else if (st_r.a_ok && st_r.a_addr == `CTRB_ADDR_DIRSEL && mode_on)
            rd_byte = {st_r.dir, 2'h0};
        else if (st_r.a_ok && st_r.a_addr == `CTRB_ADDR_MODE)
            rd_byte = {6'h00, st_r.mode};
        else if (st_r.a_ok && st_r.a_addr == `CTRB_ADDR_IRQEN)
            rd_byte = {2'h0, st_r.irq_en};
        else if (st_r.a_ok && st_r.a_addr == `CTRB_ADDR_STATUS)
            rd_byte = {4'h0, st_r.busy, st_r.busy_idx};
    end

    // Engine handshake: a grant is taken only for a still pending buffer
    assign grant_ok = tx_ev_in.grant && st_r.txq.valid && !st_r.busy
        && pend_v[st_r.txq.buf_idx];
    assign ev_end = st_r.busy
        && (tx_ev_in.done | tx_ev_in.arb_lost | tx_ev_in.bus_err | tx_ev_in.aborted);

    // Next state of bus slave, block registers and transmit handshake
    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r.bus)
            ctrb_pkg::CTRB_BUS_IDLE:
            begin
                if (addr_phase)
                begin
                    st_nxt.a_write = hwrite_in;
                    st_nxt.a_addr = haddr_in[7:0];
                    st_nxt.a_ok = haddr_in[31:8] == 24'h000000 && haddr_in[1:0] == 2'h0;
                    st_nxt.hreadyout = 1'b0;
                    st_nxt.bus = ctrb_pkg::CTRB_BUS_EXEC;
                end
            end
            ctrb_pkg::CTRB_BUS_EXEC:
            begin
                st_nxt.hreadyout = 1'b1;
                st_nxt.bus = ctrb_pkg::CTRB_BUS_IDLE;
                st_nxt.hrdata = st_r.a_write ? 32'h00000000 : {24'h000000, rd_byte};
                if (st_r.a_write && st_r.a_ok)
                begin
                    if (st_r.a_addr == `CTRB_ADDR_DIRSEL && mode_on)
                        st_nxt.dir = wbyte[7:`CTRB_DIR_LSB];
                    if (st_r.a_addr == `CTRB_ADDR_MODE)
                        st_nxt.mode = wbyte[1:0];
                    if (st_r.a_addr == `CTRB_ADDR_IRQEN)
                        st_nxt.irq_en = wbyte[5:0];
                end
            end
        endcase
        // In-progress tracking of the buffer on the wire
        if (ev_end)
            st_nxt.busy = 1'b0;
        else if (grant_ok)
        begin
            st_nxt.busy = 1'b1;
            st_nxt.busy_idx = st_r.txq.buf_idx;
        end
        // Offer the winning buffer while nothing is on the wire
        st_nxt.txq.valid = 1'b0;
        if (!st_nxt.busy && mode_on && sel_valid)
        begin
            st_nxt.txq.valid = 1'b1;
            st_nxt.txq.buf_idx = sel_idx;
            for (int i = 0; i < `CTRB_NBUF; i++)
            begin
                if (sel_idx == 3'(i))
                begin
                    st_nxt.txq.id = id_a[i];
                    st_nxt.txq.ext = ext_v[i];
                end
            end
        end
        // Abort requested for the buffer being sent
        st_nxt.abort_req = apend_v & busy_v;
        st_nxt.irq = |(sent_v & st_r.irq_en);
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
            st_r.bus <= ctrb_pkg::CTRB_BUS_IDLE;
            st_r.hreadyout <= 1'b1;
            st_r.mode <= `CTRB_MODE_RST;
            st_r.dir <= `CTRB_DIR_RST;
            st_r.irq_en <= `CTRB_IRQEN_RST;
        end
        else
            st_r <= st_nxt;
    end

    // Outputs straight from the state register; response tied to okay
    assign hrdata_out = st_r.hrdata;
    assign hreadyout_out = st_r.hreadyout;
    assign hresp_out = 1'b0;
    assign tx_req_out = st_r.txq;
    assign abort_req_out = st_r.abort_req;
    assign irq_out = st_r.irq;

endmodule : ctrb_top

// File: ctrb_top_tb_top.sv
module ctrb_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rst_b_in, hwrite, rx_load, rtr_hit, go, hrdy, hresp, irq, g_ext;
    logic [1:0] htrans, code;
    logic [31:0] haddr, hwdata, hrdata;
    logic [5:0] abort_req;
    logic [7:0] q;
    logic [2:0] g_idx;
    logic [28:0] g_id;
    logic [2:0] ord [3] = '{3'h2, 3'h3, 3'h1};
    int fail_count, compares, cnt, n0;
    ctrb_pkg::ctrb_rxf_s frame;
    ctrb_pkg::ctrb_txev_s ev;
    ctrb_pkg::ctrb_txq_s txq;
    ctrb_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .hsel_in(1'h1), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
        .tx_ev_in(ev), .rx_load_in(rx_load), .rx_buf_in(3'h5), .rx_frame_in(frame),
        .rtr_hit_in(rtr_hit), .rtr_buf_in(3'h4), .tx_req_out(txq),
        .abort_req_out(abort_req), .irq_out(irq));
    ctrb_eng_model eng (.clk_in(clk_in), .rst_b_in(rst_b_in), .tx_req_in(txq),
        .abort_req_in(abort_req), .go_in(go), .code_in(code), .ev_out(ev),
        .idx_out(g_idx), .id_out(g_id), .ext_out(g_ext), .cnt_out(cnt));
    // One AHB-Lite single word transfer
    task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(negedge clk_in); while (hrdy !== 1'h1);
        @(posedge clk_in);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(negedge clk_in); while (hrdy !== 1'h1);
        @(posedge clk_in);
        q = hrdata[7:0];
    endtask : xf
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        xf(1'h0, a, 8'h00);
        chk({24'h0, q}, {24'h0, e});
    endtask : rc
    // Lets the engine serve one frame with the given outcome
    task automatic run(input logic [1:0] c);
        int n;
        @(posedge clk_in);
        n = cnt;
        code <= c;
        go <= 1'h1;
        while (cnt == n) @(posedge clk_in);
        go <= 1'h0;
    endtask : run
    task automatic pulse(input logic rx, input ctrb_pkg::ctrb_rxf_s f);
        frame <= f;
        rx_load <= rx;
        rtr_hit <= !rx;
        @(posedge clk_in);
        rx_load <= 1'h0;
        rtr_hit <= 1'h0;
    endtask : pulse
    task automatic end_of_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        clk_in = 1'h0;
        forever #2 clk_in = !clk_in;
    end
    // Hang guard, far beyond the few hundred cycles needed
    initial
    begin
        #40000;
        fail_count++;
        end_of_test();
    end
    initial
    begin
        {hwrite, rx_load, rtr_hit, go, htrans, code} = '0;
        haddr = '0;
        hwdata = '0;
        frame = '0;
        rst_b_in = 1'h0;
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        // Legacy mode refuses the direction write, then setup
        xf(1'h1, 8'hC0, 8'h7C);
        xf(1'h1, 8'hC4, 8'h01);
        rc(8'hC0, 8'h00);
        rc(8'hFC, 8'h00);
        xf(1'h1, 8'hC0, 8'h7C);
        rc(8'hC0, 8'h7C);
        xf(1'h1, 8'hC8, 8'h01);
        xf(1'h1, 8'h04, 8'hA5);
        xf(1'h1, 8'h08, 8'hFF);
        xf(1'h1, 8'h0C, 8'h12);
        xf(1'h1, 8'h10, 8'h34);
        rc(8'h08, 8'hEB);
        rc(8'h0C, 8'h12);
        // Extended frame sent from buffer 0
        xf(1'h1, 8'h00, 8'h0B);
        run(2'h0);
        rc(8'h00, 8'h83);
        chk({3'h0, g_id}, {3'h0, 8'hA5, 3'h7, 2'h3, 8'h12, 8'h34});
        chk({31'h0, g_ext}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        $display("test send done");
        // Lost arbitration, lock, idle abort, bus error, abort on the wire
        xf(1'h1, 8'h00, 8'h08);
        run(2'h1);
        rc(8'h00, 8'h28);
        xf(1'h1, 8'h04, 8'h00);
        rc(8'h04, 8'hA5);
        xf(1'h1, 8'h00, 8'h00);
        rc(8'h00, 8'h60);
        xf(1'h1, 8'h00, 8'h08);
        run(2'h2);
        rc(8'h00, 8'h18);
        n0 = cnt;
        code <= 2'h3;
        go <= 1'h1;
        wait (ev.grant === 1'h1);
        @(posedge clk_in);
        xf(1'h1, 8'h00, 8'h00);
        while (cnt == n0) @(posedge clk_in);
        go <= 1'h0;
        rc(8'h00, 8'h50);
        $display("test status done");
        // Mixed priorities, equal ones by index
        xf(1'h1, 8'h20, 8'h09);
        xf(1'h1, 8'h40, 8'h0A);
        xf(1'h1, 8'h60, 8'h0A);
        foreach (ord[i])
        begin
            run(2'h0);
            chk({29'h0, g_idx}, {29'h0, ord[i]});
        end
        // Remote request with reply off, then on
        xf(1'h1, 8'h80, 8'h00);
        pulse(1'h0, frame);
        rc(8'h80, 8'h00);
        xf(1'h1, 8'h80, 8'h04);
        pulse(1'h0, frame);
        rc(8'h80, 8'h0C);
        run(2'h0);
        $display("test order done");
        // Receive into buffer 5
        pulse(1'h1, {8'h9C, 3'h5, 2'h2, 8'h5A, 8'hC3, 1'h1, 1'h1});
        rc(8'hA0, 8'h80);
        rc(8'hA4, 8'h9C);
        rc(8'hA8, 8'hBA);
        rc(8'hB0, 8'hC3);
        pulse(1'h1, {18'h0, 11'h5A3, 1'h0, 1'h1});
        xf(1'h1, 8'hA4, 8'h00);
        rc(8'hA4, 8'h9C);
        xf(1'h1, 8'hA0, 8'h00);
        pulse(1'h1, {18'h0, 11'h5A3, 1'h0, 1'h1});
        rc(8'hA4, 8'hB4);
        rc(8'hA8, 8'h60);
        $display("test receive done");
        end_of_test();
    end
endmodule : ctrb_top_tb_top
bind ctrb_top ctrb_chk u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .hsel_in(hsel_in),
    .htrans_in(htrans_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .tx_ev_in(tx_ev_in),
    .tx_req_out(tx_req_out), .abort_req_out(abort_req_out));
